// ---- inc/vc_resource_zero_map.vh ----
`ifndef VC_RESOURCE_ZERO_MAP_VH
`define VC_RESOURCE_ZERO_MAP_VH
`define VCR0_CAPABILITY_OFFSET   12'h0210
`define VCR0_CONTROL_OFFSET      12'h0214
`define VCR0_ADDR_WIDTH          12
`define VCR0_CAPABILITY_INDEX    10'h084
`define VCR0_CONTROL_INDEX       10'h085
`define PARB_CAP_UPSTREAM        8'h03
`define PARB_CAP_DOWNSTREAM      8'h01
`define PARB_TABLE_OFF_UPSTREAM  8'h02
`define PARB_TABLE_OFF_DOWNSTREAM 8'h00
`define TC_MAP_RESET             8'hFF
`define TC_MAP_WRITABLE_MASK     8'hFE
`define TC_MAP_LSB               0
`define TC_MAP_MSB               7
`define ADV_PKT_SWITCH_BIT       14
`define REJECT_SNOOP_BIT         15
`define MAX_TS_LSB               16
`define MAX_TS_MSB               22
`define PARB_TABLE_OFF_LSB       24
`define CHANNEL_ID_LSB           24
`define CHANNEL_ID_MSB           26
`define CHANNEL_ENABLE_BIT       31
`define AXI_RESP_OKAY            2'b00
`define AXI_RESP_SLVERR          2'b10
`endif

// ---- rtl/vc_resource_zero_config_regs.v ----
`timescale 1ns/1ps
`include "vc_resource_zero_map.vh"

// Notes on behaviour
// [RULE1] 8-bit arbitration capability mask, one bit per scheme
// [RULE2] upstream reports 0x3, downstream reports 0x1
// [RULE3] packet switch and snoop reject bits zero
// [RULE4] max time slots field held at zero
// [RULE5] table offset in 16-byte units, upstream two
// [RULE6] downstream ports report table offset zero
// [RULE7] traffic class map resets to all ones
// [RULE8] map bit 0 read-only, bits 1-7 writable
// [RULE9] channel id zero, channel enable one
// [RULE10] read-only and reserved writes ignored, read zero
module vc_resource_zero_config_regs #(
  parameter UPSTREAM = 1
) (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        resetn_in,
  // write address
  input  wire [11:0] s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output wire        s_axi_awready_out,
  // write data
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output wire        s_axi_wready_out,
  // write response
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  // read address
  input  wire [11:0] s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output wire        s_axi_arready_out,
  // read data
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  // traffic class map to the port logic
  output wire [7:0]  traffic_class_map_out
);

  ////////////////////////////////////////////////////////////////////////////
  // constant capability fields, fixed by port role

  wire [7:0] port_arb_capability_mask = (UPSTREAM != 0) ? `PARB_CAP_UPSTREAM
                                                        : `PARB_CAP_DOWNSTREAM; // [RULE1] [RULE2]
  wire [7:0] port_arb_table_offset = (UPSTREAM != 0) ? `PARB_TABLE_OFF_UPSTREAM
                                                     : `PARB_TABLE_OFF_DOWNSTREAM; // [RULE5] [RULE6]
  wire       adv_packet_switch_flag = 1'b0; // [RULE3]
  wire       reject_snoop_flag      = 1'b0; // [RULE3]
  wire [6:0] max_time_slots         = 7'h00; // [RULE4]
  wire [2:0] channel_identifier     = 3'h0; // [RULE9]
  wire       channel_enable_bit     = 1'b1; // [RULE9]

  // capability word layout, msb first:
  //   31:24 arbitration table offset, 16-byte units
  //   23    reserved, reads zero
  //   22:16 maximum time slots, not valid here
  //   15    snoop rejection, unsupported on switch ports
  //   14    advanced packet switching, unsupported
  //   13:8  reserved, reads zero
  //   7:0   arbitration scheme mask
  // every field is a constant, so the word costs no flip-flops
  wire [31:0] capability_word = {port_arb_table_offset, 1'b0, max_time_slots,
                                 reject_snoop_flag, adv_packet_switch_flag,
                                 6'h00, port_arb_capability_mask}; // [RULE10]

  // control word layout, msb first:
  //   31    channel enable, hardwired on
  //   30:27 reserved, reads zero
  //   26:24 channel identifier, hardwired zero
  //   23:8  table load and select bits live outside this block, read zero
  //   7:0   traffic class map
  reg  [7:0]  traffic_class_map;
  wire [31:0] control_word = {channel_enable_bit, 4'h0, channel_identifier,
                              16'h0000, traffic_class_map}; // [RULE10]

  assign traffic_class_map_out = traffic_class_map;

  ////////////////////////////////////////////////////////////////////////////
  // write path: address and data latched independently, in either order

  reg        aw_held;
  reg [11:0] aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;

  wire        aw_now   = aw_held | (s_axi_awvalid_in & s_axi_awready_out);
  wire        w_now    = w_held | (s_axi_wvalid_in & s_axi_wready_out);
  wire [11:0] wr_addr  = aw_held ? aw_addr : s_axi_awaddr_in;
  wire [31:0] wr_data  = w_held ? w_data : s_axi_wdata_in;
  wire [3:0]  wr_strb  = w_held ? w_strb : s_axi_wstrb_in;
  wire        wr_fire  = aw_now & w_now & !s_axi_bvalid_out;
  wire        wr_ctl   = (wr_addr[11:2] == `VCR0_CONTROL_INDEX);
  wire        wr_cap   = (wr_addr[11:2] == `VCR0_CAPABILITY_INDEX);

  // writes to the read-only capability word are accepted and dropped,
  // so software probing it sees no error
  wire [1:0]  wr_resp  = (wr_ctl || wr_cap) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR; // [RULE10]

  // only the upper seven map bits follow software; bit 0 keeps its value
  wire [7:0]  next_traffic_class_map = (wr_data[7:0] & `TC_MAP_WRITABLE_MASK) |
                                       (traffic_class_map & ~`TC_MAP_WRITABLE_MASK); // [RULE8]

  // address channel: a taken address waits here until its data arrives
  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end
  end

  // data channel: taken data waits here until its address arrives
  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end
  end

  // write response: wr_fire needs bvalid low, so set and clear never meet
  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `AXI_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_resp;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // traffic class map: only byte lane 0 carries it
  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      traffic_class_map <= `TC_MAP_RESET; // [RULE7]
    end else if (wr_fire && wr_ctl && wr_strb[0]) begin
      traffic_class_map <= next_traffic_class_map; // [RULE8] [RULE10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: one cycle to data

  assign s_axi_arready_out = !s_axi_rvalid_out;

  reg [31:0] next_rdata;
  reg [1:0]  next_rresp;

  // unmapped words answer an error with zero data rather than stale data
  always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = `AXI_RESP_OKAY;
    case (s_axi_araddr_in[11:2])
      `VCR0_CAPABILITY_INDEX: next_rdata = capability_word;
      `VCR0_CONTROL_INDEX:    next_rdata = control_word;
      default:                next_rresp = `AXI_RESP_SLVERR; // [RULE10]
    endcase
  end

  // data and response stay put while rvalid waits for rready
  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= next_rdata;
      s_axi_rresp_out  <= next_rresp;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // limitations
  //   one write and one read are held at a time; a second request waits
  //   on ready rather than queueing, which keeps the bank to a few flops
  //   address bits 1:0 are ignored, so any byte address in a word hits it
  //   only strobe lane 0 matters, since the upper control bytes are fixed

endmodule

// ---- verif/vc_resource_zero_config_regs_sva.sv ----
`timescale 1ns/1ps
module vc_resource_zero_config_regs_sva #(parameter UPSTREAM = 1) (
  input wire        clk_sys_in, resetn_in, s_axi_awvalid_in, s_axi_awready_out,
  input wire        s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in,
  input wire        s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in,
  input wire [11:0] s_axi_awaddr_in, s_axi_araddr_in,
  input wire [31:0] s_axi_wdata_in, s_axi_rdata_out,
  input wire [3:0]  s_axi_wstrb_in,
  input wire [1:0]  s_axi_bresp_out, s_axi_rresp_out,
  input wire [7:0]  traffic_class_map_out);
  wire       rd = s_axi_arvalid_in && s_axi_arready_out;
  wire [9:0] ra = s_axi_araddr_in[11:2];
  wire [6:0] wd = s_axi_wdata_in[7:1];
  wire       wt = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  a_map_lsb: assert property (traffic_class_map_out[0]) else $error("map bit 0 low");
  a_cap_read: assert property (rd && ra == 10'h084 |=> s_axi_rdata_out ==
    (UPSTREAM ? 32'h0200_0003 : 32'h0000_0001)) else $error("capability word wrong");
  a_ctl_read: assert property (rd && ra == 10'h085 |=> s_axi_rdata_out[0] &&
    s_axi_rdata_out[31:8] == 24'h80_0000) else $error("control fixed bits wrong");
  a_bad_read: assert property (rd && ra != 10'h084 && ra != 10'h085 |=> s_axi_rvalid_out &&
    s_axi_rresp_out == 2'b10 && s_axi_rdata_out == 32'h0) else $error("unmapped read wrong");
  a_map_write: assert property (wt && s_axi_awaddr_in[11:2] == 10'h085 && s_axi_wstrb_in[0]
    |=> traffic_class_map_out == {$past(wd), 1'b1}) else $error("map write lost");
  a_map_hold: assert property (!$rose(s_axi_bvalid_out) |-> $stable(traffic_class_map_out))
    else $error("map changed without write");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out &&
    $stable(s_axi_bresp_out)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out &&
    $stable(s_axi_rdata_out)) else $error("read data dropped");
  cover property (wt && s_axi_awaddr_in[11:2] == 10'h085);
  cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'b10);
  cover property (s_axi_rvalid_out && !s_axi_rready_in);
endmodule
bind vc_resource_zero_config_regs vc_resource_zero_config_regs_sva #(.UPSTREAM(UPSTREAM)) chk_i (.*);

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        c = 0, rn = 0, av = 0, wv = 0, br = 0, rv = 0, rr = 0;
  logic [11:0] aa = 0, ra = 0;
  logic [31:0] wd = 0, d;
  logic [3:0]  ws = 0;
  logic [33:0] e, q[$];
  logic [7:0]  m = 8'hFF;
  wire         awr, wrd, bv, arr, rvo;
  wire  [1:0]  bre, rre;
  wire  [31:0] rd;
  wire  [7:0]  tcm;
  wire         dawr, dwrd, dbv, darr, drvo;
  wire  [1:0]  dbre, drre;
  wire  [31:0] drd;
  wire  [7:0]  dtcm;
  int          errors = 0, cmp_count = 0, cyc = 0;
  vc_resource_zero_config_regs dut (.clk_sys_in(c), .resetn_in(rn), .s_axi_awaddr_in(aa),
    .s_axi_awvalid_in(av), .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(bre), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(br), .s_axi_araddr_in(ra), .s_axi_arvalid_in(rv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rd), .s_axi_rresp_out(rre), .s_axi_rvalid_out(rvo), .s_axi_rready_in(rr),
    .traffic_class_map_out(tcm));
  // downstream port on the same bus; it answers in the same cycles as dut
  vc_resource_zero_config_regs #(.UPSTREAM(0)) dn (.clk_sys_in(c), .resetn_in(rn),
    .s_axi_awaddr_in(aa), .s_axi_awvalid_in(av), .s_axi_awready_out(dawr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(dwrd),
    .s_axi_bresp_out(dbre), .s_axi_bvalid_out(dbv), .s_axi_bready_in(br),
    .s_axi_araddr_in(ra), .s_axi_arvalid_in(rv), .s_axi_arready_out(darr),
    .s_axi_rdata_out(drd), .s_axi_rresp_out(drre), .s_axi_rvalid_out(drvo),
    .s_axi_rready_in(rr), .traffic_class_map_out(dtcm));
  initial forever #10 c = ~c;
  task chk(input [33:0] s, x);
    cmp_count++;
    if (s !== x) begin
      errors++;
      $display("BAD bus_word exp %h seen %h", x, s);
    end
  endtask
  task complete_run;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // each channel is released at the rising edge that samples its ready high
  task xfer(input bit w, input [11:0] a, input [31:0] dd, input [3:0] s, input [33:0] x);
    bit got_a;
    bit got_d;
    q.push_back(x);
    got_a = 0;
    got_d = 0;
    if (w) begin
      aa <= a;
      wd <= dd;
      ws <= s;
      av <= 1;
      wv <= 1;
      do begin
        @(posedge c);
        if (awr && !got_a) begin
          got_a = 1;
          av <= 0;
        end
        if (wrd && !got_d) begin
          got_d = 1;
          wv <= 0;
        end
      end while (!(got_a && got_d));
    end else begin
      ra <= a;
      rv <= 1;
      do @(posedge c); while (!arr);
      rv <= 0;
    end
    repeat ($urandom % 3) @(posedge c);
    if (w) br <= 1;
    else rr <= 1;
    do @(posedge c); while (w ? !bv : !rvo);
    br <= 0;
    rr <= 0;
  endtask
  always @(posedge c) begin
    cyc++;
    if (cyc > 3000) begin errors++; complete_run; end
  end
  always @(posedge c) if (bv && br || rvo && rr) begin
    e = q.pop_front();
    chk(bv ? {bre, 32'h0} : {rre, rd}, e);
  end
  initial begin
    void'($urandom(44));
    repeat (8) @(posedge c);
    rn <= 1;
    xfer(0, 12'h210, 0, 0, {2'b00, 32'h0200_0003});
    chk({drre, drd}, {2'b00, 32'h0000_0001});
    xfer(0, 12'h214, 0, 0, {2'b00, 32'h8000_00FF});
    repeat (6) begin
      d = $urandom;
      xfer(1, 12'h214, d, d[11:8], 34'h0);
      if (d[8]) m = {d[7:1], 1'b1};
      xfer(0, 12'h214, 0, 0, {2'b00, 8'h80, 16'h0, m});
    end
    chk({26'h0, tcm}, {26'h0, m});
    chk({26'h0, dtcm}, {26'h0, m});
    xfer(1, 12'h210, '1, 4'hF, 34'h0);
    xfer(0, 12'h210, 0, 0, {2'b00, 32'h0200_0003});
    xfer(1, 12'h218, '1, 4'hF, {2'b10, 32'h0});
    xfer(0, 12'h3FC, 0, 0, {2'b10, 32'h0});
    rn <= 0;
    repeat (2) @(posedge c);
    rn <= 1;
    xfer(0, 12'h214, 0, 0, {2'b00, 32'h8000_00FF});
    complete_run;
  end
endmodule
